// ### src/ppdo_defines.svh
// register offsets, field positions, reset values for the parallel port
// assumes a plain register port with 4-bit word address
`ifndef PPDO_DEFINES_SVH
`define PPDO_DEFINES_SVH
`define PPDO_ADDR_W 4
`define PPDO_OFF_DIR_A 4'h0
`define PPDO_OFF_DIR_B 4'h1
`define PPDO_OFF_DIR_C 4'h2
`define PPDO_OFF_DIR_D 4'h3
`define PPDO_OFF_OUT_A 4'h4
`define PPDO_OFF_OUT_B 4'h5
`define PPDO_OFF_OUT_C 4'h6
`define PPDO_OFF_OUT_D 4'h7
`define PPDO_OFF_IN_A 4'h8
`define PPDO_OFF_IN_B 4'h9
`define PPDO_OFF_IN_C 4'ha
`define PPDO_OFF_IN_D 4'hb
`define PPDO_OFF_PIN_CMD 4'hc
`define PPDO_OFF_COPY 4'hd
`define PPDO_DIR_RST 8'h00
`define PPDO_OUT_RST 8'h00
`define PPDO_FIX_OUT_BIT 0
`define PPDO_FIX_IN_BIT 3
`define PPDO_CMD_PORT_LSB 3
`define PPDO_CMD_OP_LSB 5
`endif

// ### src/ppdo_pkg.sv
// types for the parallel port block
// used by ppdo_port and the testbench
package ppdo_pkg;
   typedef enum logic [1:0] {
      PPDO_OP_LOW,
      PPDO_OP_HIGH,
      PPDO_OP_TOGGLE,
      PPDO_OP_INPUT
   } ppdo_op_t;
endpackage

// ### src/ppdo_port.sv
// four 8-bit gpio ports with direction and output latches
// assumes pins arrive asynchronous; pad tristate outside
`timescale 1ns/100ps
`include "ppdo_defines.svh"
module ppdo_port
   import ppdo_pkg::*;
#(
   parameter int NPORTS = 4,
   parameter bit SMALL_PKG = 1'b0
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [`PPDO_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [NPORTS*8-1:0] pin_i,
   output logic [NPORTS*8-1:0] pin_o,
   output logic [NPORTS*8-1:0] pin_oe_o
);
   logic [7:0] dir_r [NPORTS];
   logic [7:0] dir_nxt [NPORTS];
   logic [7:0] out_r [NPORTS];
   logic [7:0] out_nxt [NPORTS];
   logic [7:0] sync1_r [NPORTS];
   logic [7:0] sync2_r [NPORTS];
   logic [NPORTS*8-1:0] pin_o_nxt;
   logic [NPORTS*8-1:0] oe_nxt;
   logic [7:0] rdata_nxt;
   logic [7:0] rdata_r;

   // fixed pins apply to port a only, and only in small mode
   function automatic logic [7:0] eff_dir(input logic [7:0] d,
                                          input int p);
      logic [7:0] e;
      e = d;
      if (SMALL_PKG && p == 0) begin
         e[`PPDO_FIX_OUT_BIT] = 1'b1;
         e[`PPDO_FIX_IN_BIT] = 1'b0;
      end
      return e;
   endfunction

   logic cmd_wr;
   logic [1:0] cmd_port;
   logic [2:0] cmd_bit;
   ppdo_op_t cmd_op;
   assign cmd_wr = wr_i && addr_i == `PPDO_OFF_PIN_CMD;
   assign cmd_bit = wdata_i[2:0];
   assign cmd_port = wdata_i[`PPDO_CMD_PORT_LSB +: 2];
   assign cmd_op = ppdo_op_t'(wdata_i[`PPDO_CMD_OP_LSB +: 2]);

   genvar g;
   generate
      for (g = 0; g < NPORTS; g++) begin : g_port
         always_comb begin
            dir_nxt[g] = dir_r[g];
            out_nxt[g] = out_r[g];
            if (wr_i && addr_i == `PPDO_ADDR_W'(`PPDO_OFF_DIR_A + g)) begin
               dir_nxt[g] = wdata_i;
            end else if (wr_i &&
                  addr_i == `PPDO_ADDR_W'(`PPDO_OFF_OUT_A + g)) begin
               out_nxt[g] = wdata_i;
            end else if (wr_i && addr_i == `PPDO_OFF_COPY) begin
               out_nxt[g] = sync2_r[g];
            end else if (cmd_wr && cmd_port == 2'(g)) begin
               // pin commands imply direction, except the input op
               dir_nxt[g][cmd_bit] = (cmd_op != PPDO_OP_INPUT);
               if (cmd_op == PPDO_OP_HIGH)
                  out_nxt[g][cmd_bit] = 1'b1;
               else if (cmd_op == PPDO_OP_LOW)
                  out_nxt[g][cmd_bit] = 1'b0;
               else if (cmd_op == PPDO_OP_TOGGLE)
                  out_nxt[g][cmd_bit] = ~out_r[g][cmd_bit];
            end
            // drive only where effective direction is output
            oe_nxt[g*8 +: 8] = eff_dir(dir_nxt[g], g);
            pin_o_nxt[g*8 +: 8] = out_nxt[g] &
                                  eff_dir(dir_nxt[g], g);
         end

         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               dir_r[g] <= `PPDO_DIR_RST;
               out_r[g] <= `PPDO_OUT_RST;
               sync1_r[g] <= 8'h00;
               sync2_r[g] <= 8'h00;
            end else begin
               dir_r[g] <= dir_nxt[g];
               out_r[g] <= out_nxt[g];
               sync1_r[g] <= pin_i[g*8 +: 8];
               sync2_r[g] <= sync1_r[g];
            end
         end
      end
   endgenerate

   // input registers read the synchronised pins; in small mode port a
   // shares one pin set for input and output, set by the pad wiring
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_i) begin
         for (int p = 0; p < NPORTS; p++) begin
            if (addr_i == `PPDO_ADDR_W'(`PPDO_OFF_DIR_A + p))
               rdata_nxt = eff_dir(dir_r[p], p);
            else if (addr_i == `PPDO_ADDR_W'(`PPDO_OFF_OUT_A + p))
               rdata_nxt = out_r[p];
            else if (addr_i == `PPDO_ADDR_W'(`PPDO_OFF_IN_A + p))
               rdata_nxt = sync2_r[p];
         end
      end
   end

   // fixed output pin is not configurable, so it leaves reset driven
   localparam logic [NPORTS*8-1:0] OE_RST =
      (NPORTS*8)'(SMALL_PKG) << `PPDO_FIX_OUT_BIT;
   logic [NPORTS*8-1:0] pin_o_r;
   logic [NPORTS*8-1:0] oe_r;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_r <= 8'h00;
         pin_o_r <= '0;
         oe_r <= OE_RST;
      end else begin
         rdata_r <= rdata_nxt;
         pin_o_r <= pin_o_nxt;
         oe_r <= oe_nxt;
      end
   end
   assign rdata_o = rdata_r;
   assign pin_o = pin_o_r;
   assign pin_oe_o = oe_r;

   chk_dir_drives_oe: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_DIR_B |=> pin_oe_o[15:8] == $past(wdata_i))
      else $error("direction write did not reach enables");

   chk_word_write: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_OUT_B |=>
         pin_o[15:8] == ($past(wdata_i) & pin_oe_o[15:8]))
      else $error("output word not applied in one cycle");

   chk_undriven_low: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      (pin_o & ~pin_oe_o) == '0)
      else $error("input pin carries drive value");

   chk_cmd_sets_dir: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      cmd_wr && cmd_op == PPDO_OP_HIGH && cmd_port == 2'd1 |=>
         pin_oe_o[8 + $past(cmd_bit)] && pin_o[8 + $past(cmd_bit)])
      else $error("pin command did not make pin an output");

   chk_sync_delay: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      rd_i && addr_i == `PPDO_OFF_IN_A |=>
         rdata_o == $past(pin_i[7:0], 3))
      else $error("input read not two stages late");

   chk_fixed_pins: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      SMALL_PKG |-> pin_oe_o[0] && !pin_oe_o[3])
      else $error("fixed pins wrong in small mode");

   chk_copy_port: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_COPY |=>
         out_r[0] == $past(sync2_r[0]))
      else $error("copy did not load latch from inputs");

   chk_rd_unmapped: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      rd_i && addr_i > `PPDO_OFF_IN_D |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");

   // port a enables follow the word only outside small mode
   chk_dir_port_a: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      !SMALL_PKG && wr_i && addr_i == `PPDO_OFF_DIR_A |=>
         pin_oe_o[7:0] == $past(wdata_i))
      else $error("port a direction write lost");

   chk_dir_small_a: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      SMALL_PKG && wr_i && addr_i == `PPDO_OFF_DIR_A |=>
         pin_oe_o[7:0] == (($past(wdata_i) | 8'h01) & 8'hf7))
      else $error("fixed pins followed a direction write");

   chk_dir_port_c: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_DIR_C |=>
         pin_oe_o[23:16] == $past(wdata_i))
      else $error("port c direction write lost");

   chk_dir_port_d: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_DIR_D |=>
         pin_oe_o[31:24] == $past(wdata_i))
      else $error("port d direction write lost");

   chk_out_port_a: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_OUT_A |=>
         pin_o[7:0] == ($past(wdata_i) & pin_oe_o[7:0]))
      else $error("port a drive levels wrong");

   chk_out_port_c: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_OUT_C |=>
         pin_o[23:16] == ($past(wdata_i) & pin_oe_o[23:16]))
      else $error("port c word not applied in one cycle");

   chk_out_port_d: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_OUT_D |=>
         pin_o[31:24] == ($past(wdata_i) & pin_oe_o[31:24]))
      else $error("port d word not applied in one cycle");

   // a latch write never touches direction
   chk_out_keeps_oe: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_OUT_B |=>
         pin_oe_o[15:8] == $past(pin_oe_o[15:8]))
      else $error("latch write changed a direction");

   chk_cmd_low: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      cmd_wr && cmd_op == PPDO_OP_LOW && cmd_port == 2'd1 |=>
         pin_oe_o[8 + $past(cmd_bit)] && !pin_o[8 + $past(cmd_bit)])
      else $error("low command did not drive pin low");

   chk_cmd_toggle: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      cmd_wr && cmd_op == PPDO_OP_TOGGLE && cmd_port == 2'd1 |=>
         pin_o[8 + $past(cmd_bit)] != $past(out_r[1][cmd_bit]))
      else $error("toggle command did not invert pin");

   chk_cmd_input: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      cmd_wr && cmd_op == PPDO_OP_INPUT && cmd_port == 2'd1 |=>
         !pin_oe_o[8 + $past(cmd_bit)] && !pin_o[8 + $past(cmd_bit)])
      else $error("input command left pin driven");

   chk_cmd_other_port: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      cmd_wr && cmd_port == 2'd1 |->
         oe_nxt[7:0] == pin_oe_o[7:0] && pin_o_nxt[7:0] == pin_o[7:0])
      else $error("pin command reached another port");

   // read data stands one cycle only, zero otherwise
   chk_rd_idle_zero: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data without a read");

   chk_rd_dir_b: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      rd_i && addr_i == `PPDO_OFF_DIR_B |=> rdata_o == $past(dir_r[1]))
      else $error("port b direction read wrong");

   chk_rd_out_b: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      rd_i && addr_i == `PPDO_OFF_OUT_B |=> rdata_o == $past(out_r[1]))
      else $error("port b latch read wrong");

   chk_rd_in_b: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      rd_i && addr_i == `PPDO_OFF_IN_B |=>
         rdata_o == $past(pin_i[15:8], 3))
      else $error("port b input read not two stages late");

   chk_copy_port_b: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i == `PPDO_OFF_COPY |=>
         pin_o[15:8] == ($past(sync2_r[1]) & pin_oe_o[15:8]))
      else $error("copy did not reach port b pins");

   // unmapped writes must leave every pad as it was
   chk_unmapped_wr: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      wr_i && addr_i > `PPDO_OFF_COPY |->
         oe_nxt == pin_oe_o && pin_o_nxt == pin_o)
      else $error("unmapped write changed the pads");

   chk_fixed_dir_read: assert property (
      @(posedge core_clk_i) disable iff (!nrst_i)
      SMALL_PKG && rd_i && addr_i == `PPDO_OFF_DIR_A |=>
         rdata_o[0] && !rdata_o[3])
      else $error("fixed pins read back wrong");

   cov_dir_write: cover property (@(posedge core_clk_i)
      wr_i && addr_i == `PPDO_OFF_DIR_A);
   cov_pin_cmd: cover property (@(posedge core_clk_i) cmd_wr);
   cov_copy: cover property (@(posedge core_clk_i)
      wr_i && addr_i == `PPDO_OFF_COPY);
   cov_in_read: cover property (@(posedge core_clk_i)
      rd_i && addr_i == `PPDO_OFF_IN_A);
   cov_cmd_toggle: cover property (@(posedge core_clk_i)
      cmd_wr && cmd_op == PPDO_OP_TOGGLE);
endmodule // ppdo_port

// ### verif/ppdo_pad_model.sv
// pad model: external circuits sitting on the port pins
// assumes plain tristate pads, levels from the bench when undriven
`timescale 1ns/100ps
module ppdo_pad_model #(
   parameter int W = 32
) (
   input wire logic [W-1:0] drv_i,
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] ext_i,
   output logic [W-1:0] lvl_o
);
   // a driven pad reads back its own drive
   assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // ppdo_pad_model

// ### verif/testbench.sv
// bench for ppdo_port: table of port writes, then hand tests
// assumes ppdo_pad_model on the pads and a second small-mode copy
`timescale 1ns/100ps
`include "ppdo_defines.svh"
module testbench;
   import ppdo_pkg::*;
   typedef struct {logic [3:0] g; logic [7:0] dir, out, exp_o;} ppdo_row_t;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] ext_lvl = 32'h0000_0000;
   logic [31:0] pin_i, pin_o, pin_oe_o, s_pin_o, s_oe;
   logic [7:0] rdata_o, s_rdata;
   int n_mismatch = 0;
   int n_compared = 0;
   ppdo_row_t rows [4] = '{'{4'h0, 8'h03, 8'h03, 8'h03},
      '{4'h1, 8'h0f, 8'ha5, 8'h05}, '{4'h2, 8'hff, 8'h81, 8'h81},
      '{4'h3, 8'h80, 8'hff, 8'h80}};
   ppdo_op_t ops [4] = '{PPDO_OP_HIGH, PPDO_OP_LOW, PPDO_OP_TOGGLE,
      PPDO_OP_INPUT};
   logic [1:0] cmd_exp [4] = '{2'b11, 2'b10, 2'b11, 2'b00};
   always #10 core_clk_i = ~core_clk_i;
   ppdo_port u_ppdo_port (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
   ppdo_port #(.SMALL_PKG(1'b1)) u_ppdo_port_small (.core_clk_i(core_clk_i),
      .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(s_rdata), .pin_i(pin_i), .pin_o(s_pin_o),
      .pin_oe_o(s_oe));
   ppdo_pad_model u_ppdo_pad_model (.drv_i(pin_o), .oe_i(pin_oe_o),
      .ext_i(ext_lvl), .lvl_o(pin_i));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(negedge core_clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk(32'(rdata_o), 32'(exp));
   endtask
   task automatic close_out;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, well past the longest sequence
   initial begin
      #1000000;
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      chk(pin_oe_o | s_oe, 32'h1);
      nrst_i <= 1'b1;
      rd(`PPDO_OFF_DIR_D, 8'h00);
      foreach (rows[i]) begin
         // direction first, so the latch write reaches the pads
         wr(rows[i].g, rows[i].dir);
         wr(rows[i].g + 4'h4, rows[i].out);
         chk(32'(pin_oe_o[rows[i].g*8+:8]), 32'(rows[i].dir));
         chk(32'(pin_o[rows[i].g*8+:8]), 32'(rows[i].exp_o));
         rd(rows[i].g, rows[i].dir);
      end
      chk(pin_oe_o, 32'h80ff0f03);
      chk(pin_o, 32'h80810503);
      ext_lvl <= 32'h5a5a5a5a;
      repeat (4) @(posedge core_clk_i);
      rd(`PPDO_OFF_IN_B, 8'h55);
      rd(`PPDO_OFF_IN_A, 8'h5b);
      wr(`PPDO_OFF_DIR_C, 8'h00);
      repeat (4) @(posedge core_clk_i);
      wr(`PPDO_OFF_COPY, 8'h00);
      wr(`PPDO_OFF_DIR_C, 8'hff);
      chk(32'(pin_o[23:16]), 32'h5a);
      foreach (ops[k]) begin
         wr(`PPDO_OFF_PIN_CMD, {1'b0, ops[k], 2'd1, 3'd6});
         chk(32'({pin_oe_o[14], pin_o[14]}), 32'(cmd_exp[k]));
      end
      // unmapped places must neither act nor answer
      wr(4'hf, 8'hff);
      chk(pin_oe_o, 32'h80ff0f03);
      rd(4'hf, 8'h00);
      wr(`PPDO_OFF_DIR_A, 8'hff);
      chk(32'(s_oe[7:0]), 32'hf7);
      wr(`PPDO_OFF_DIR_A, 8'h00);
      chk(32'(s_oe[7:0]), 32'h01);
      close_out();
   end
endmodule // testbench
